// ---- verilog/ccs_consts.svh ----
// Purpose: constants of the clock-synthesizer control block
// Assumes: included by its bare name
// Notes: offsets, field positions, reset values and timing counts
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH
// serial protocol bytes
`define CCS_SLAVE_ADDR 8'hd2
`define CCS_CMD_CODE 8'h00
`define CCS_CNT_MIN 6'h01
`define CCS_CNT_MAX 6'h20
// position of each received byte in a transfer
`define CCS_BYTE_ADDR 6'h00
`define CCS_BYTE_CMD 6'h01
`define CCS_BYTE_CNT 6'h02
`define CCS_BYTE_DATA0 6'h03
`define CCS_BYTE_LAST 6'h3f
// control byte fields and writable reset values
`define CCS_BIT_SPREAD 7
`define CCS_BIT_VCH 5
`define CCS_BIT_PCIRUN 3
`define CCS_RST_SPREAD 1'b0
`define CCS_RST_VCH 1'b0
`define CCS_RST_PCIRUN 1'b1
// three-level mode pin encoding
`define CCS_MODE_LOW 2'h0
`define CCS_MODE_MID 2'h1
`define CCS_MODE_HIGH 2'h2
// controller register offsets
`define CCS_REG_CTRL 4'h0
`define CCS_REG_DATA0 4'h4
`define CCS_REG_COUNT 4'h8
`define CCS_REG_STATUS 4'hc
// timing: quarter of a 100 kHz serial bit, least time, rounded up
`define CCS_CLK_NS 25
`define CCS_QTR_NS 2500
`define CCS_QTR_CYC ((`CCS_QTR_NS + `CCS_CLK_NS - 1) / `CCS_CLK_NS)
`endif

// ---- verilog/ccs_pkg.sv ----
// Purpose: types shared by both ends of the control link
// Assumes: nothing
// Notes: state enums only; numbers live in ccs_consts.svh
package ccs_pkg;
	// serial slave states
	typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_ACK} ccs_slv_e;
	// serial master states
	typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} ccs_host_e;
endpackage : ccs_pkg

// ---- verilog/ccs_if.sv ----
// Purpose: two-wire serial link between controller and clock device
// Assumes: open drain, enable high pulls the wire low
// Notes: resolves wire levels from the enables of both parties
`timescale 1ns/1ps
`default_nettype none
interface ccs_if;
	logic host_scl_out; // level driven when enabled
	logic host_scl_oe; // controller pulls clock low
	logic host_sda_out; // level driven when enabled
	logic host_sda_oe; // controller pulls data low
	logic dev_sda_out; // level driven when enabled
	logic dev_sda_oe; // device pulls data low (acknowledge)
	logic scl; // resolved clock wire, pulled up
	logic sda; // resolved data wire, pulled up
	assign scl = ~(host_scl_oe & ~host_scl_out);
	assign sda = ~((host_sda_oe & ~host_sda_out) | (dev_sda_oe & ~dev_sda_out));
	modport host (output host_scl_out, host_scl_oe, host_sda_out,
		host_sda_oe, input scl, sda);
	modport dev (output dev_sda_out, dev_sda_oe, input scl, sda);
endinterface : ccs_if
`default_nettype wire

// ---- verilog/ccs_sync.sv ----
// Purpose: two-flop synchroniser for a vector of asynchronous levels
// Assumes: each bit is an independent level
// Notes: only stage two may be read by logic
`timescale 1ns/1ps
`default_nettype none
module ccs_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// levels in and out
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] s1_q; // first stage, read only by stage two
	logic [W-1:0] s2_q; // second stage
	genvar g;
	// one synchroniser pair per bit
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					s1_q[g] <= RST_VAL[g];
					s2_q[g] <= RST_VAL[g];
				end else begin
					s1_q[g] <= i_async[g];
					s2_q[g] <= s1_q[g];
				end
			end
		end
	endgenerate
	assign o_sync = s2_q;
endmodule : ccs_sync
`default_nettype wire

// ---- verilog/ccs_dev.sv ----
// Purpose: clock device control: strap decode, output gating, serial slave
// Assumes: serial bit rate far below the core clock; test clock < 20 MHz
// Notes: outputs are control levels for the analog clock drivers
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ccs_consts.svh"
// Behaviour
// - test mode divides test clock per group
// - mid mode, frequency low: all outputs float
// - power-down: iref times two, comp float high, rest low
// - answer only address d2 write
// - direction bit zero means write
// - only block writes, no indexing
// - bytes ascend msb first, partial kept
// - command 00h then byte count
// - count excludes command and count bytes
// - count between 1 and 32
// - valid once count acknowledge sampled
// - power-up defaults need no access
// - bit 7 enables down spread
// - bit 5 picks video 66 or 48
// - bit 3 clear stops pci outputs
// - bits 2,1 show latched straps
// - straps latched once on strobe low
module ccs_dev (
	// clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_RESET,
	// serial link
	ccs_if.dev bus,
	// straps
	input wire logic [1:0] I_MODE_SELECT_PIN,
	input wire logic I_FREQ_SELECT_PIN,
	input wire logic I_CURRENT_MULTIPLIER_SEL,
	input wire logic I_STRAP_VALID_STROBE_N,
	// power, stop and test clock pins
	input wire logic I_POWER_DOWN_N,
	input wire logic I_PCI_STOP_N,
	input wire logic I_TEST_CLOCK_IN,
	// frequency plan
	output logic O_CPU_133,
	output logic O_EXT_SIXTY_SIX_MODE,
	output logic O_TEST_MODE,
	output logic O_ALL_HIZ,
	output logic O_TEST_DIV2,
	output logic O_TEST_DIV4,
	output logic O_TEST_DIV8,
	output logic O_TEST_REF,
	// gating
	output logic O_CPU_IREF_X2,
	output logic O_CPU_COMP_FLOAT,
	output logic O_OSC_ON,
	output logic O_CORE_RUN,
	output logic O_PCI_STOP_RUN,
	// configuration
	output logic O_SPREAD_EN,
	output logic O_VCH_48,
	output logic O_CURRENT_MULT,
	output logic [7:0] O_CTRL_BYTE
);
	import ccs_pkg::*;
	// synchronised pins
	logic [9:0] pin_s;
	logic [1:0] mode_s;
	logic freq_s, mult_s, strobe_n_s, pd_n_s, stop_n_s, test_clock_in_s, scl_s, sda_s;
	ccs_sync #(.W(10), .RST_VAL(10'h3b)) u_sync (
		.i_clk(I_CORE_CLK),
		.i_rst(I_RESET),
		.i_async({I_MODE_SELECT_PIN, I_FREQ_SELECT_PIN,
			I_CURRENT_MULTIPLIER_SEL, I_STRAP_VALID_STROBE_N,
			I_POWER_DOWN_N, I_PCI_STOP_N, I_TEST_CLOCK_IN,
			bus.scl, bus.sda}),
		.o_sync(pin_s)
	);
	assign {mode_s, freq_s, mult_s, strobe_n_s, pd_n_s, stop_n_s, test_clock_in_s,
		scl_s, sda_s} = pin_s;

	// strap latch state
	logic latched_q, latched_d; // strobe already seen
	logic [1:0] smode_q, smode_d; // latched mode level
	logic sfreq_q, sfreq_d; // latched frequency select
	logic smult_q, smult_d; // latched current multiplier
	// latch straps at the first low strobe, then ignore it
	always_comb begin
		latched_d = latched_q;
		smode_d = smode_q;
		sfreq_d = sfreq_q;
		smult_d = smult_q;
		if (!latched_q && !strobe_n_s) begin
			latched_d = 1'b1;
			smode_d = mode_s;
			sfreq_d = freq_s;
			smult_d = mult_s;
		end
	end
	always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			latched_q <= 1'b0;
			smode_q <= `CCS_MODE_LOW;
			sfreq_q <= 1'b0;
			smult_q <= 1'b0;
		end else begin
			latched_q <= latched_d;
			smode_q <= smode_d;
			sfreq_q <= sfreq_d;
			smult_q <= smult_d;
		end
	end

	// serial slave state
	ccs_slv_e st_q, st_d; // receive state
	logic [2:0] bit_q, bit_d; // bits received in this byte
	logic [5:0] byte_q, byte_d; // byte position in transfer
	logic [7:0] sh_q, sh_d; // receive shift register
	logic got_q, got_d; // full byte waiting for its acknowledge
	logic valid_q, valid_d; // count acknowledged, data may land
	logic ack_q, ack_d; // pulls data low
	logic scl_p_q, sda_p_q; // previous wire samples
	logic spread_q, spread_d; // control byte bit 7
	logic vch_q, vch_d; // control byte bit 5
	logic run_q, run_d; // control byte bit 3
	logic scl_rise, scl_fall, start_c, stop_c;
	assign scl_rise = scl_s & ~scl_p_q;
	assign scl_fall = ~scl_s & scl_p_q;
	assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;

	// byte receiver: start, shift, acknowledge, store
	always_comb begin
		st_d = st_q;
		bit_d = bit_q;
		byte_d = byte_q;
		sh_d = sh_q;
		got_d = got_q;
		valid_d = valid_q;
		ack_d = ack_q;
		spread_d = spread_q;
		vch_d = vch_q;
		run_d = run_q;
		if (start_c) begin
			// every transfer restarts at the address byte
			st_d = ST_RX;
			bit_d = 3'h0;
			byte_d = `CCS_BYTE_ADDR;
			got_d = 1'b0;
			valid_d = 1'b0;
			ack_d = 1'b0;
		end else if (stop_c) begin
			// stored bytes stay; only the receiver goes idle
			st_d = ST_IDLE;
			ack_d = 1'b0;
		end else begin
			unique case (st_q)
				ST_IDLE: begin
					// wait for a start
				end
				ST_RX: begin
					if (scl_rise) begin
						sh_d = {sh_q[6:0], sda_s};
						bit_d = bit_q + 3'h1;
						got_d = (bit_q == 3'h7);
					end else if (scl_fall && got_q) begin
						got_d = 1'b0;
						if (byte_q == `CCS_BYTE_ADDR &&
							sh_q != `CCS_SLAVE_ADDR) begin
							st_d = ST_IDLE;
						end else if (byte_q == `CCS_BYTE_CMD &&
							sh_q != `CCS_CMD_CODE) begin
							st_d = ST_IDLE;
						end else begin
							st_d = ST_ACK;
							ack_d = 1'b1;
							if (byte_q == `CCS_BYTE_DATA0 && valid_q) begin
								// reserved and strap bits ignore writes
								spread_d = sh_q[`CCS_BIT_SPREAD];
								vch_d = sh_q[`CCS_BIT_VCH];
								run_d = sh_q[`CCS_BIT_PCIRUN];
							end
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						ack_d = 1'b0;
						st_d = ST_RX;
						if (byte_q == `CCS_BYTE_CNT) begin
							valid_d = 1'b1;
						end
						if (byte_q != `CCS_BYTE_LAST) begin
							byte_d = byte_q + 6'h01;
						end
					end
				end
			endcase
		end
	end
	always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			st_q <= ST_IDLE;
			bit_q <= 3'h0;
			byte_q <= `CCS_BYTE_ADDR;
			sh_q <= 8'h00;
			got_q <= 1'b0;
			valid_q <= 1'b0;
			ack_q <= 1'b0;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			spread_q <= `CCS_RST_SPREAD;
			vch_q <= `CCS_RST_VCH;
			run_q <= `CCS_RST_PCIRUN;
		end else begin
			st_q <= st_d;
			bit_q <= bit_d;
			byte_q <= byte_d;
			sh_q <= sh_d;
			got_q <= got_d;
			valid_q <= valid_d;
			ack_q <= ack_d;
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
			spread_q <= spread_d;
			vch_q <= vch_d;
			run_q <= run_d;
		end
	end
	assign bus.dev_sda_out = 1'b0;
	assign bus.dev_sda_oe = ack_q;

	// test clock divider counts synchronised rising edges
	logic test_clock_in_p_q; // previous test clock sample
	logic [2:0] div_q, div_d; // bit n toggles at test clock / 2^(n+1)
	always_comb begin
		div_d = div_q;
		if (test_clock_in_s && !test_clock_in_p_q) begin
			div_d = div_q + 3'h1;
		end
	end
	always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			test_clock_in_p_q <= 1'b0;
			div_q <= 3'h0;
		end else begin
			test_clock_in_p_q <= test_clock_in_s;
			div_q <= div_d;
		end
	end

	// decoded plan and gating, registered onto the outputs
	logic mode_hi, mode_mid, test_c;
	assign mode_hi = (smode_q == `CCS_MODE_HIGH);
	assign mode_mid = (smode_q == `CCS_MODE_MID);
	assign test_c = mode_mid & sfreq_q;
	always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			O_CPU_133 <= 1'b0;
			O_EXT_SIXTY_SIX_MODE <= 1'b0;
			O_TEST_MODE <= 1'b0;
			O_ALL_HIZ <= 1'b0;
			O_TEST_DIV2 <= 1'b0;
			O_TEST_DIV4 <= 1'b0;
			O_TEST_DIV8 <= 1'b0;
			O_TEST_REF <= 1'b0;
			O_CPU_IREF_X2 <= 1'b0;
			O_CPU_COMP_FLOAT <= 1'b0;
			O_OSC_ON <= 1'b0;
			O_CORE_RUN <= 1'b0;
			O_PCI_STOP_RUN <= 1'b0;
			O_SPREAD_EN <= 1'b0;
			O_VCH_48 <= 1'b0;
			O_CURRENT_MULT <= 1'b0;
			O_CTRL_BYTE <= 8'h19;
		end else begin
			O_CPU_133 <= ~mode_mid & sfreq_q;
			O_EXT_SIXTY_SIX_MODE <= mode_hi;
			O_TEST_MODE <= test_c;
			O_ALL_HIZ <= mode_mid & ~sfreq_q;
			O_TEST_DIV2 <= test_c & div_q[0];
			O_TEST_DIV4 <= test_c & div_q[1];
			O_TEST_DIV8 <= test_c & div_q[2];
			O_TEST_REF <= test_c & test_clock_in_s;
			O_CPU_IREF_X2 <= ~pd_n_s;
			O_CPU_COMP_FLOAT <= ~pd_n_s;
			O_OSC_ON <= pd_n_s;
			O_CORE_RUN <= pd_n_s;
			O_PCI_STOP_RUN <= pd_n_s & stop_n_s & run_q;
			O_SPREAD_EN <= spread_q;
			O_VCH_48 <= vch_q;
			O_CURRENT_MULT <= smult_q;
			// fixed reserved bits beside the live fields
			O_CTRL_BYTE <= {spread_q, 1'b0, vch_q, 1'b1, run_q, mode_hi,
				sfreq_q, 1'b1};
		end
	end
endmodule : ccs_dev
`default_nettype wire

// ---- verilog/ccs_host.sv ----
// Purpose: serial controller sending block writes to the clock device
// Assumes: software port with read data one cycle after the strobe
// Notes: no clock stretching; bytes after byte 0 are sent as zero
`timescale 1ns/1ps
`default_nettype none
`include "ccs_consts.svh"
module ccs_host (
	// clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_RESET,
	// serial link
	ccs_if.host bus,
	// software port
	input wire logic [3:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [7:0] O_RDATA
);
	import ccs_pkg::*;
	logic sda_s; // synchronised data wire
	ccs_sync #(.W(1), .RST_VAL(1'b1)) u_sync (
		.i_clk(I_CORE_CLK),
		.i_rst(I_RESET),
		.i_async(bus.sda),
		.o_sync(sda_s)
	);

	// register file state
	logic [7:0] data0_q, data0_d; // value for data byte 0
	logic [5:0] cnt_q, cnt_d; // requested byte count
	logic busy_q, busy_d; // transfer running
	logic done_q, done_d; // sticky: transfer ended
	logic nack_q, nack_d; // sticky: device refused a byte
	logic [7:0] rd_q, rd_d; // read data register
	logic go_c, end_c, nak_c; // start request, engine events
	logic [5:0] cnt_eff; // count clamped to the legal range
	assign cnt_eff = (cnt_q < `CCS_CNT_MIN) ? `CCS_CNT_MIN :
		(cnt_q > `CCS_CNT_MAX) ? `CCS_CNT_MAX : cnt_q;
	assign go_c = I_WR && I_ADDR == `CCS_REG_CTRL && I_WDATA[0] && !busy_q;
	// register writes, reads and sticky flags; a set beats a clear
	always_comb begin
		data0_d = data0_q;
		cnt_d = cnt_q;
		busy_d = busy_q;
		done_d = done_q;
		nack_d = nack_q;
		rd_d = 8'h00;
		if (I_WR && I_ADDR == `CCS_REG_DATA0) begin
			data0_d = I_WDATA;
		end
		if (I_WR && I_ADDR == `CCS_REG_COUNT) begin
			cnt_d = I_WDATA[5:0];
		end
		if (I_WR && I_ADDR == `CCS_REG_STATUS) begin
			done_d = done_q & ~I_WDATA[1];
			nack_d = nack_q & ~I_WDATA[2];
		end
		if (go_c) begin
			busy_d = 1'b1;
		end
		if (end_c) begin
			busy_d = 1'b0;
			done_d = 1'b1;
		end
		if (nak_c) begin
			nack_d = 1'b1;
		end
		if (I_RD) begin
			unique case (I_ADDR)
				`CCS_REG_DATA0: rd_d = data0_q;
				`CCS_REG_COUNT: rd_d = {2'b00, cnt_q};
				`CCS_REG_STATUS: rd_d = {5'h00, nack_q, done_q, busy_q};
				default: rd_d = 8'h00;
			endcase
		end
	end
	always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			data0_q <= 8'h19;
			cnt_q <= `CCS_CNT_MIN;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			nack_q <= 1'b0;
			rd_q <= 8'h00;
		end else begin
			data0_q <= data0_d;
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
			nack_q <= nack_d;
			rd_q <= rd_d;
		end
	end
	assign O_RDATA = rd_q;

	// serial engine state
	ccs_host_e hs_q, hs_d; // engine state
	logic [6:0] q_q, q_d; // cycles within a quarter bit
	logic [1:0] ph_q, ph_d; // quarter within a bit
	logic [3:0] bn_q, bn_d; // bit in byte, 8 is the acknowledge
	logic [5:0] by_q, by_d; // byte position in the transfer
	logic scl_oe_q, scl_oe_d; // pulls clock low
	logic sda_oe_q, sda_oe_d; // pulls data low
	logic tick;
	logic [7:0] tx; // byte being sent
	assign tick = (q_q == 7'(`CCS_QTR_CYC - 1));
	// address with write direction, command, count, then data
	always_comb begin
		unique case (by_q)
			`CCS_BYTE_ADDR: tx = `CCS_SLAVE_ADDR;
			`CCS_BYTE_CMD: tx = `CCS_CMD_CODE;
			`CCS_BYTE_CNT: tx = {2'b00, cnt_eff};
			`CCS_BYTE_DATA0: tx = data0_q;
			default: tx = 8'h00;
		endcase
	end
	// bit sequencer: start, nine-bit bytes, stop
	always_comb begin
		hs_d = hs_q;
		q_d = (hs_q == HS_IDLE || tick) ? 7'h00 : q_q + 7'h01;
		ph_d = ph_q;
		bn_d = bn_q;
		by_d = by_q;
		end_c = 1'b0;
		nak_c = 1'b0;
		scl_oe_d = 1'b0;
		sda_oe_d = 1'b0;
		if (tick) begin
			ph_d = ph_q + 2'h1;
		end
		unique case (hs_q)
			HS_IDLE: begin
				ph_d = 2'h0;
				if (go_c) begin
					hs_d = HS_START;
				end
			end
			HS_START: begin
				sda_oe_d = ph_q[1];
				if (tick && ph_q == 2'h3) begin
					hs_d = HS_BIT;
					bn_d = 4'h0;
					by_d = `CCS_BYTE_ADDR;
				end
			end
			HS_BIT: begin
				scl_oe_d = ~ph_q[1];
				sda_oe_d = (bn_q < 4'h8) && !tx[3'(4'h7 - bn_q)];
				if (tick && ph_q == 2'h3) begin
					if (bn_q != 4'h8) begin
						bn_d = bn_q + 4'h1;
					end else begin
						bn_d = 4'h0;
						// acknowledge sampled while the clock is high
						if (sda_s) begin
							nak_c = 1'b1;
							hs_d = HS_STOP;
						end else if (by_q == cnt_eff + 6'h02) begin
							hs_d = HS_STOP;
						end else begin
							by_d = by_q + 6'h01;
						end
					end
				end
			end
			HS_STOP: begin
				scl_oe_d = (ph_q == 2'h0);
				sda_oe_d = (ph_q != 2'h3);
				if (tick && ph_q == 2'h3) begin
					hs_d = HS_IDLE;
					end_c = 1'b1;
				end
			end
		endcase
	end
	always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			hs_q <= HS_IDLE;
			q_q <= 7'h00;
			ph_q <= 2'h0;
			bn_q <= 4'h0;
			by_q <= `CCS_BYTE_ADDR;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else begin
			hs_q <= hs_d;
			q_q <= q_d;
			ph_q <= ph_d;
			bn_q <= bn_d;
			by_q <= by_d;
			scl_oe_q <= scl_oe_d;
			sda_oe_q <= sda_oe_d;
		end
	end
	assign bus.host_scl_out = 1'b0;
	assign bus.host_scl_oe = scl_oe_q;
	assign bus.host_sda_out = 1'b0;
	assign bus.host_sda_oe = sda_oe_q;
endmodule : ccs_host
`default_nettype wire

// ---- sim/ccs_properties.sv ----
// Purpose: wire-level properties of the serial control link
// Assumes: quarter bit of 100 core cycles, one clock domain
// Notes: watches the interface signals only, no bind
`timescale 1ns/1ps
`default_nettype none
module ccs_properties (
	// clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_RESET,
	// link signals
	input wire logic host_scl_oe,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	default clocking cb @(posedge I_CORE_CLK);
	endclocking
	default disable iff (I_RESET);
	// open-drain wires follow every party's enable
	a_scl_wire_level: assert property (scl == !host_scl_oe)
		else $error("clock wire level wrong");
	a_sda_wire_level: assert property (sda == !(host_sda_oe | dev_sda_oe))
		else $error("data wire level wrong");
	// acknowledge only changes while the clock is low
	a_ack_rise_low: assert property ($rose(dev_sda_oe) |-> !scl)
		else $error("ack raised with clock high");
	a_ack_fall_low: assert property ($fell(dev_sda_oe) |-> !scl)
		else $error("ack dropped with clock high");
	a_ack_stable_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
		else $error("ack moved during clock high");
	// one acknowledge spans one whole bit of 400 cycles
	a_ack_holds: assert property ($rose(dev_sda_oe) |-> dev_sda_oe[*8])
		else $error("ack glitch");
	a_ack_length: assert property ($rose(dev_sda_oe) |-> ##[380:420] $fell(dev_sda_oe))
		else $error("ack length wrong");
	// controller listens while the device acknowledges
	a_host_released: assert property (dev_sda_oe && scl |-> !host_sda_oe)
		else $error("controller drives data during ack");
	// clock low phase is one or two quarters
	a_scl_low_phase: assert property ($fell(scl) |-> ##[90:210] $rose(scl))
		else $error("clock low phase wrong");
	// main scenarios: ack, start and stop
	c_ack: cover property ($rose(dev_sda_oe));
	c_start: cover property (scl && $fell(sda));
	c_stop: cover property (scl && $rose(sda));
endmodule : ccs_properties
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench joining controller and clock device
// Assumes: 40 MHz core clock, straps re-latched after each reset of the modes test only
// Notes: expected values come from the control byte layout
`timescale 1ns/1ps
`default_nettype none
`include "ccs_consts.svh"
module tb_top;
	logic I_CORE_CLK, I_RESET; // clock and reset
	logic [1:0] mode; // three-level mode strap
	logic freq, mult, strobe_n, pd_n, stop_n, test_clock_in; // pins
	logic [3:0] addr; // software port
	logic [7:0] wdata, rdata, ctrl, s;
	logic wr, rd;
	logic cpu133, ext66, tmode, hiz, d2, d4, d8, tref; // plan
	logic iref2, cfloat, osc, core, pcirun, spread, vch48, cmult;
	logic ack_q; // previous ack enable, for edge count
	integer error_cnt = 0, checked = 0, cyc = 0, acks = 0;
	ccs_if link();
	ccs_dev ccs_dev_i (.I_CORE_CLK(I_CORE_CLK), .I_RESET(I_RESET),
		.bus(link.dev), .I_MODE_SELECT_PIN(mode), .I_FREQ_SELECT_PIN(freq),
		.I_CURRENT_MULTIPLIER_SEL(mult), .I_STRAP_VALID_STROBE_N(strobe_n),
		.I_POWER_DOWN_N(pd_n), .I_PCI_STOP_N(stop_n), .I_TEST_CLOCK_IN(test_clock_in),
		.O_CPU_133(cpu133), .O_EXT_SIXTY_SIX_MODE(ext66),
		.O_TEST_MODE(tmode), .O_ALL_HIZ(hiz), .O_TEST_DIV2(d2),
		.O_TEST_DIV4(d4), .O_TEST_DIV8(d8), .O_TEST_REF(tref),
		.O_CPU_IREF_X2(iref2), .O_CPU_COMP_FLOAT(cfloat), .O_OSC_ON(osc),
		.O_CORE_RUN(core), .O_PCI_STOP_RUN(pcirun), .O_SPREAD_EN(spread),
		.O_VCH_48(vch48), .O_CURRENT_MULT(cmult), .O_CTRL_BYTE(ctrl));
	ccs_host ccs_host_i (.I_CORE_CLK(I_CORE_CLK), .I_RESET(I_RESET),
		.bus(link.host), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
		.I_RD(rd), .O_RDATA(rdata));
	ccs_properties ccs_properties_i (.I_CORE_CLK(I_CORE_CLK),
		.I_RESET(I_RESET), .host_scl_oe(link.host_scl_oe),
		.host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe),
		.scl(link.scl), .sda(link.sda));
	// clock generator
	initial begin
		I_CORE_CLK = 1'b0;
		forever #12.5 I_CORE_CLK = ~I_CORE_CLK;
	end
	// counts acks on the wire and cuts a hang short
	always @(posedge I_CORE_CLK) begin
		cyc++;
		ack_q <= link.dev_sda_oe;
		if (link.dev_sda_oe && !ack_q) acks++;
		if (cyc == 80000) begin
			$display("timeout");
			error_cnt++;
			give_verdict();
		end
	end
	// compare and count
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// reset held for 8 cycles
	task rst;
		@(posedge I_CORE_CLK);
		I_RESET <= 1'b1;
		repeat (8) @(posedge I_CORE_CLK);
		I_RESET <= 1'b0;
		repeat (4) @(posedge I_CORE_CLK);
	endtask : rst
	// one-cycle software write
	task sw_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge I_CORE_CLK);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge I_CORE_CLK);
		wr <= 1'b0;
	endtask : sw_wr
	// read, data taken in the cycle after the strobe
	task sw_rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge I_CORE_CLK);
		rd <= 1'b1;
		addr <= a;
		@(posedge I_CORE_CLK);
		rd <= 1'b0;
		@(negedge I_CORE_CLK);
		d = rdata;
	endtask : sw_rd
	// power-up values without serial access
	task t_defaults;
		rst();
		sw_rd(`CCS_REG_STATUS, s);
		chk("status", 8'h00, s);
		sw_rd(`CCS_REG_DATA0, s);
		chk("data0", 8'h19, s);
		sw_rd(4'h2, s);
		chk("unmapped", 8'h00, s);
		chk("ctrl byte", 8'h19, ctrl);
		chk("spread", 8'h00, {7'h00, spread});
		chk("video sel", 8'h00, {7'h00, vch48});
		chk("pci run", 8'h01, {7'h00, pcirun});
		$display("defaults test done");
	endtask : t_defaults
	// test clock at 1 MHz, 32 periods, rising edges counted
	task t_divs;
		integer n [4];
		logic [3:0] p;
		n = '{0, 0, 0, 0};
		p = 4'h0;
		for (int i = 0; i < 1280; i++) begin
			@(posedge I_CORE_CLK);
			if (i % 20 == 0) test_clock_in <= ~test_clock_in;
			for (int k = 0; k < 4; k++) if ({d8, d4, d2, tref}[k] && !p[k]) n[k]++;
			p = {d8, d4, d2, tref};
		end
		for (int k = 0; k < 4; k++) chk("divider", 8'h01, 8'((n[k] >= (32 >> k) - 1) && (n[k] <= (32 >> k) + 1)));
	endtask : t_divs
	// every mode and frequency strap pair, multiplier tied to frequency, latched once on strobe low
	task t_modes;
		logic [1:0] m;
		logic f;
		for (int i = 0; i < 6; i++) begin
			m = 2'(i / 2);
			f = 1'(i % 2);
			rst();
			mode <= m;
			freq <= f;
			mult <= f;
			strobe_n <= 1'b0;
			repeat (10) @(posedge I_CORE_CLK);
			strobe_n <= 1'b1;
			mode <= (m == `CCS_MODE_LOW) ? `CCS_MODE_HIGH : `CCS_MODE_LOW;
			freq <= ~f;
			mult <= ~f;
			repeat (4) @(posedge I_CORE_CLK);
			strobe_n <= 1'b0;
			repeat (10) @(posedge I_CORE_CLK);
			strobe_n <= 1'b1;
			@(negedge I_CORE_CLK);
			chk("cpu 133", 8'(f && m != `CCS_MODE_MID), 8'(cpu133));
			chk("ext 66", 8'(m == `CCS_MODE_HIGH), 8'(ext66));
			chk("test mode", 8'(m == `CCS_MODE_MID && f), 8'(tmode));
			chk("all hiz", 8'(m == `CCS_MODE_MID && !f), 8'(hiz));
			chk("mult", 8'(f), 8'(cmult));
			chk("strap bits", 8'({m == `CCS_MODE_HIGH, f}), 8'(ctrl[2:1]));
			if (m == `CCS_MODE_MID && f) t_divs();
		end
		$display("modes test done");
	endtask : t_modes
	// power-down and pci stop table
	task t_gating;
		rst();
		for (int i = 0; i < 4; i++) begin
			pd_n <= i[1];
			stop_n <= i[0];
			repeat (6) @(posedge I_CORE_CLK);
			@(negedge I_CORE_CLK);
			chk("gating", 8'({!i[1], !i[1], i[1], i[1], i[1] & i[0]}), 8'({iref2, cfloat, osc, core, pcirun}));
		end
		$display("gating test done");
	endtask : t_gating
	// one block write, judged by wire acks, status and control byte
	task run_xfer(input logic [7:0] c, input logic [7:0] d,
		input logic [7:0] a, input logic [7:0] exp);
		sw_wr(`CCS_REG_COUNT, c);
		sw_wr(`CCS_REG_DATA0, d);
		acks = 0;
		sw_wr(`CCS_REG_CTRL, 8'h01);
		s = 8'h00;
		for (int n = 0; n < 20000 && s[1] !== 1'b1; n++) sw_rd(`CCS_REG_STATUS, s);
		chk("status done", 8'h02, s);
		chk("acks", a, 8'(acks));
		chk("ctrl byte", exp, ctrl);
		sw_wr(`CCS_REG_STATUS, 8'h06);
		sw_rd(`CCS_REG_STATUS, s);
		chk("status clear", 8'h00, s);
	endtask : run_xfer
	// count zero is clamped, then a three-byte write
	task t_serial;
		rst();
		run_xfer(8'h00, 8'he0, 8'h04, 8'hb1);
		chk("spread on", 8'h01, 8'(spread));
		chk("video 48", 8'h01, 8'(vch48));
		chk("pci stopped", 8'h00, 8'(pcirun));
		run_xfer(8'h03, 8'h08, 8'h06, 8'h19);
		chk("pci running", 8'h01, 8'(pcirun));
		$display("serial test done");
	endtask : t_serial
	// closing report
	task give_verdict;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict
	// main sequence
	initial begin
		I_RESET = 1'b1;
		{mode, freq, mult, test_clock_in, wr, rd, ack_q} = '0;
		{strobe_n, pd_n, stop_n} = 3'h7;
		addr = 4'h0;
		wdata = 8'h00;
		t_defaults();
		t_modes();
		t_gating();
		t_serial();
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
